// >>> pkg/timer_defines.svh
// register indices, field positions, reset values and prescale figures of the timer block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ******************************************
// register indices (byte address = 4 * index)
// ******************************************
`define IDX_EDGE_POLARITY   6'h03
`define IDX_TIMER_A_CTRL    6'h18
`define IDX_TIMER_B_CTRL    6'h1A
`define IDX_TIMER_CD_CTRL   6'h1D
`define IDX_TIMER_A_RELOAD  6'h1E
`define IDX_TIMER_B_RELOAD  6'h1F
`define IDX_TIMER_C_RELOAD  6'h20
`define IDX_TIMER_D_RELOAD  6'h21

// ******************************************
// field positions
// ******************************************
`define AB_MODE_MSB         3
`define AB_OUT_RESET_BIT    4
`define CD_C_MODE_MSB       6
`define CD_C_MODE_LSB       4
`define CD_D_MODE_MSB       2
`define EDGE_BIT_A          4
`define EDGE_BIT_B          3
`define MODE_EVENT_BIT      3

// ******************************************
// values
// ******************************************
`define RESET_BYTE          8'h00
`define LVL_AFTER_RESET     2'h3    // both aux and io levels read active while edge bits and pins rest at zero
`define COUNT_TERMINAL      8'h01
`define MODE_STOPPED        4'h0
`define MODE_EVENT          4'h8
`define PRESC_CODE_STOP     3'h0
`define DIV_4               8'h04
`define DIV_10              8'h0A
`define DIV_16              8'h10
`define DIV_50              8'h32
`define DIV_64              8'h40
`define DIV_100             8'h64
`define DIV_200             8'hC8
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// >>> pkg/timer_pkg.sv
// types shared by the prescaled timer block
package timer_pkg;

    // operating mode after decoding a mode field
    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_DELAY,
        MODE_EVENT_COUNT,
        MODE_PULSE_WIDTH
    } timer_mode_t;

    // working state of one timer
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] reload;
        logic [7:0] presc;
        logic       out;
    } timer_state_t;

    // one AXI4-Lite read answer
    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } axi_rd_t;

endpackage

// >>> hdl/four_channel_prescaled_timer.sv
// four 8-bit prescaled down-counter timers with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "timer_defines.svh"

module four_channel_prescaled_timer
    import timer_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // auxiliary inputs and general-purpose lines
    input  wire logic              timer_a_aux_input,
    input  wire logic              timer_b_aux_input,
    input  wire logic              io_line_four,
    input  wire logic              io_line_three,
    // timer outputs and event pulses
    output logic                   timer_a_output,
    output logic                   timer_b_output,
    output logic                   timer_c_output,
    output logic                   timer_d_output,
    output logic [3:0]             timeout_pulse,
    output logic                   io_four_event,
    output logic                   io_three_event
);

    // ******************************************
    // helper functions
    // ******************************************

    // prescale code to divisor
    function automatic logic [7:0] presc_div(input logic [2:0] code);
        case (code)
            3'h1:    presc_div = `DIV_4;
            3'h2:    presc_div = `DIV_10;
            3'h3:    presc_div = `DIV_16;
            3'h4:    presc_div = `DIV_50;
            3'h5:    presc_div = `DIV_64;
            3'h6:    presc_div = `DIV_100;
            3'h7:    presc_div = `DIV_200;
            default: presc_div = `DIV_4;
        endcase
    endfunction

    // mode field to operating mode
    function automatic timer_mode_t mode_of(input logic [3:0] code);
        if (code == `MODE_STOPPED) begin
            mode_of = MODE_STOP;
        end else if (code == `MODE_EVENT) begin
            mode_of = MODE_EVENT_COUNT;
        end else if (code[`MODE_EVENT_BIT]) begin
            mode_of = MODE_PULSE_WIDTH;
        end else begin
            mode_of = MODE_DELAY;
        end
    endfunction

    // ******************************************
    // registers
    // ******************************************
    logic [7:0]   edge_polarity_register;
    logic [7:0]   timer_a_control;
    logic [7:0]   timer_b_control;
    logic [7:0]   timer_cd_control;
    timer_state_t tmr_reg [4];
    logic [3:0]   mode_code [4];
    timer_mode_t  mode [4];
    logic [1:0]   aux_meta_reg;
    logic [1:0]   aux_sync_reg;
    logic [1:0]   aux_lvl_prev_reg;
    logic [1:0]   io_prev_reg;
    logic [1:0]   io_lvl_prev_reg;
    logic [1:0]   aux_lvl;
    logic [1:0]   aux_edge;
    logic [1:0]   io_lvl;
    logic [1:0]   edge_bit;
    logic [3:0]   tick;
    logic [3:0]   run;
    logic         wr_fire;
    logic         ar_fire;
    logic         wr_en;
    logic [5:0]   wr_idx;
    logic [5:0]   rd_idx;
    logic [3:0]   reload_wr;
    axi_rd_t      rd_next;

    // mode codes of the four timers
    assign mode_code[0] = timer_a_control[`AB_MODE_MSB:0];
    assign mode_code[1] = timer_b_control[`AB_MODE_MSB:0];
    assign mode_code[2] = {1'b0, timer_cd_control[`CD_C_MODE_MSB:`CD_C_MODE_LSB]};
    assign mode_code[3] = {1'b0, timer_cd_control[`CD_D_MODE_MSB:0]};

    // ******************************************
    // AXI4-Lite slave
    // ******************************************
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign wr_idx  = s_axi_awaddr[7:2];
    assign rd_idx  = s_axi_araddr[7:2];
    assign wr_en   = wr_fire && s_axi_wstrb[0];

    // write handshake: take address and data together, then answer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                case (wr_idx)
                    `IDX_EDGE_POLARITY, `IDX_TIMER_A_CTRL, `IDX_TIMER_B_CTRL, `IDX_TIMER_CD_CTRL,
                    `IDX_TIMER_A_RELOAD, `IDX_TIMER_B_RELOAD, `IDX_TIMER_C_RELOAD,
                    `IDX_TIMER_D_RELOAD: s_axi_bresp <= `RESP_OKAY;
                    default:             s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux over the live registers; its output is captured at the read strobe
    always_comb begin
        rd_next = '{data: 32'h0000_0000, resp: `RESP_OKAY};
        case (rd_idx)
            `IDX_EDGE_POLARITY:  rd_next.data[7:0] = edge_polarity_register;
            `IDX_TIMER_A_CTRL:   rd_next.data[7:0] = timer_a_control;
            `IDX_TIMER_B_CTRL:   rd_next.data[7:0] = timer_b_control;
            `IDX_TIMER_CD_CTRL:  rd_next.data[7:0] = timer_cd_control;
            `IDX_TIMER_A_RELOAD: rd_next.data[7:0] = tmr_reg[0].count;
            `IDX_TIMER_B_RELOAD: rd_next.data[7:0] = tmr_reg[1].count;
            `IDX_TIMER_C_RELOAD: rd_next.data[7:0] = tmr_reg[2].count;
            `IDX_TIMER_D_RELOAD: rd_next.data[7:0] = tmr_reg[3].count;
            default:             rd_next.resp      = `RESP_SLVERR;
        endcase
    end

    // read handshake: the accept edge is the data strobe that captures counts
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_next.data;
                s_axi_rresp  <= rd_next.resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control register writes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            edge_polarity_register <= `RESET_BYTE;
            timer_a_control        <= `RESET_BYTE;
            timer_b_control        <= `RESET_BYTE;
            timer_cd_control       <= `RESET_BYTE;
        end else if (clk_en && wr_en) begin
            case (wr_idx)
                `IDX_EDGE_POLARITY: edge_polarity_register <= s_axi_wdata[7:0];
                `IDX_TIMER_A_CTRL:  timer_a_control  <= {3'h0, s_axi_wdata[`AB_OUT_RESET_BIT:0]};
                `IDX_TIMER_B_CTRL:  timer_b_control  <= {3'h0, s_axi_wdata[`AB_OUT_RESET_BIT:0]};
                `IDX_TIMER_CD_CTRL: timer_cd_control <= {1'b0, s_axi_wdata[`CD_C_MODE_MSB:`CD_C_MODE_LSB],
                                                         1'b0, s_axi_wdata[`CD_D_MODE_MSB:0]};
                default: ;
            endcase
        end
    end

    // reload write strobes per timer
    always_comb begin
        reload_wr    = 4'h0;
        reload_wr[0] = wr_en && (wr_idx == `IDX_TIMER_A_RELOAD);
        reload_wr[1] = wr_en && (wr_idx == `IDX_TIMER_B_RELOAD);
        reload_wr[2] = wr_en && (wr_idx == `IDX_TIMER_C_RELOAD);
        reload_wr[3] = wr_en && (wr_idx == `IDX_TIMER_D_RELOAD);
    end

    // ******************************************
    // auxiliary inputs
    // ******************************************

    // two-stage synchroniser on the aux inputs, one stage on the io lines, then a history stage for edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aux_meta_reg     <= 2'h0;
            aux_sync_reg     <= 2'h0;
            aux_lvl_prev_reg <= `LVL_AFTER_RESET;                                     // no false edge after reset
            io_prev_reg      <= 2'h0;
            io_lvl_prev_reg  <= `LVL_AFTER_RESET;
        end else if (clk_en) begin
            aux_meta_reg     <= {timer_b_aux_input, timer_a_aux_input};
            aux_sync_reg     <= aux_meta_reg;
            aux_lvl_prev_reg <= aux_lvl;
            io_prev_reg      <= {io_line_three, io_line_four};
            io_lvl_prev_reg  <= io_lvl;
        end
    end

    // exclusive-or detector: edge bit change moves the level too
    assign edge_bit[0] = edge_polarity_register[`EDGE_BIT_A];
    assign edge_bit[1] = edge_polarity_register[`EDGE_BIT_B];
    assign aux_lvl     = ~(aux_sync_reg ^ edge_bit);
    assign aux_edge    = aux_lvl & ~aux_lvl_prev_reg;
    assign io_lvl      = ~({io_prev_reg[1], io_prev_reg[0]} ^ edge_bit);

    // channel events: aux in special modes, else the plain io line
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            io_four_event  <= 1'b0;
            io_three_event <= 1'b0;
        end else if (clk_en) begin
            case (mode[0])
                MODE_PULSE_WIDTH: io_four_event <= ~aux_lvl[0] & aux_lvl_prev_reg[0];
                MODE_EVENT_COUNT: io_four_event <= aux_edge[0];
                default:          io_four_event <= io_lvl[0] & ~io_lvl_prev_reg[0];
            endcase
            case (mode[1])
                MODE_PULSE_WIDTH: io_three_event <= ~aux_lvl[1] & aux_lvl_prev_reg[1];
                MODE_EVENT_COUNT: io_three_event <= aux_edge[1];
                default:          io_three_event <= io_lvl[1] & ~io_lvl_prev_reg[1];
            endcase
        end
    end

    // ******************************************
    // timer cores
    // ******************************************

    // mode decode, run gating and count pulses
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            mode[i] = mode_of(mode_code[i]);
            run[i]  = 1'b0;
            tick[i] = 1'b0;
            case (mode[i])
                MODE_DELAY: begin
                    run[i]  = 1'b1;
                    tick[i] = (tmr_reg[i].presc == 8'h00);
                end
                MODE_PULSE_WIDTH: begin
                    run[i]  = (i < 2) ? aux_lvl[i % 2] : 1'b0;
                    tick[i] = run[i] && (tmr_reg[i].presc == 8'h00);
                end
                MODE_EVENT_COUNT: begin
                    run[i]  = 1'b1;
                    tick[i] = (i < 2) ? aux_edge[i % 2] : 1'b0;
                end
                default: ;
            endcase
        end
    end

    // prescaler, down counter, reload and output toggle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                tmr_reg[i] <= '{count: `RESET_BYTE, reload: `RESET_BYTE, presc: `RESET_BYTE, out: 1'b0};
            end
            timeout_pulse <= 4'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                timeout_pulse[i] <= 1'b0;
                // prescaler: discarded when stopped, held while gated off
                if (mode[i] == MODE_STOP || mode[i] == MODE_EVENT_COUNT) begin
                    tmr_reg[i].presc <= presc_div(mode_code[i][2:0]) - 8'h01;
                end else if (run[i]) begin
                    tmr_reg[i].presc <= tick[i] ? presc_div(mode_code[i][2:0]) - 8'h01
                                                : tmr_reg[i].presc - 8'h01;
                end
                if (reload_wr[i]) begin
                    tmr_reg[i].reload <= s_axi_wdata[7:0];
                end
                // main counter: 00 wraps to FF, giving 256 pulses per timeout
                if (reload_wr[i] && !run[i]) begin
                    tmr_reg[i].count <= s_axi_wdata[7:0];
                end else if (tick[i] && tmr_reg[i].count == `COUNT_TERMINAL) begin
                    tmr_reg[i].count <= reload_wr[i] ? s_axi_wdata[7:0]
                                                     : tmr_reg[i].reload;
                    timeout_pulse[i] <= 1'b1;
                    tmr_reg[i].out   <= ~tmr_reg[i].out;
                end else if (tick[i]) begin
                    tmr_reg[i].count <= tmr_reg[i].count - 8'h01;
                end
            end
            // software may force the A and B outputs back to reset state
            if (timer_a_control[`AB_OUT_RESET_BIT]) begin
                tmr_reg[0].out <= 1'b0;
            end
            if (timer_b_control[`AB_OUT_RESET_BIT]) begin
                tmr_reg[1].out <= 1'b0;
            end
        end
    end

    // outputs come straight from the output flip-flops
    assign timer_a_output = tmr_reg[0].out;
    assign timer_b_output = tmr_reg[1].out;
    assign timer_c_output = tmr_reg[2].out;
    assign timer_d_output = tmr_reg[3].out;

endmodule

// >>> sim/four_channel_prescaled_timer_props.sv
// port checker for the prescaled timer block
`timescale 1ns/1ps
module timer_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // timer outputs
    input wire logic        timer_a_output,
    input wire logic        timer_c_output,
    input wire logic [3:0]  timeout_pulse
);
    // ********************
    // properties
    // ********************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // bus handshake steps
    sequence wr_take; s_axi_awready && s_axi_wready; endsequence
    sequence rd_take; s_axi_arready; endsequence
    ready_pair_a: assert property (s_axi_awready |-> s_axi_wready) else $error("write readies apart");
    wr_resp_a: assert property (wr_take |=> s_axi_bvalid && !s_axi_awready) else $error("no write response");
    b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response stuck");
    rd_resp_a: assert property (rd_take ##1 s_axi_rready |-> s_axi_rvalid ##1 !s_axi_rvalid)
        else $error("read response wrong");
    rd_clean_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
        && (s_axi_rresp == 2'h0 || s_axi_rdata == 32'h0)) else $error("read data not clean");
    pulse_one_a: assert property (|timeout_pulse |=> (timeout_pulse & $past(timeout_pulse)) == 4'h0)
        else $error("timeout pulse too long");
    c_toggle_a: assert property ($changed(timer_c_output) |-> timeout_pulse[2] || $past(timeout_pulse[2]))
        else $error("output c toggled without timeout");
    rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> !timer_a_output && !timer_c_output
        && !s_axi_bvalid && !s_axi_rvalid) else $error("reset left state");
endmodule

// >>> sim/aux_source.sv
// model of an external source driving one auxiliary timer input
`timescale 1ns/1ps
module aux_source (
    // clock and command
    input wire logic       clk_sys,
    input wire logic       go,
    input wire logic [3:0] n,
    // driven line
    output logic           line
);
    logic [3:0] left = 4'h0;
    logic [1:0] gap = 2'h0;
    initial line = 1'b0;
    // toggles n times, never faster than once per four clocks
    always @(posedge clk_sys) begin
        if (go) begin
            left <= n;
        end else if (left != 4'h0) begin
            gap <= gap + 2'h1;
            if (gap == 2'h3) begin
                line <= ~line;
                left <= left - 4'h1;
            end
        end
    end
endmodule

// >>> sim/four_channel_prescaled_timer_test.sv
// self-checking bench for the prescaled timer block
`timescale 1ns/1ps
`include "timer_defines.svh"
module four_channel_prescaled_timer_test;
    // ********************
    // signals
    // ********************
    logic clk_sys = 0, sys_rst = 1, clk_en = 1, go_a = 0, go_b = 0, o, io4 = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_four_event, io_three_event;
    logic timer_a_aux_input, timer_b_aux_input, timer_a_output, timer_b_output, timer_c_output, timer_d_output;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF, timeout_pulse, n_tog = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int mismatches = 0, n_compared = 0, cyc = 0, ev4 = 0, ev3 = 0, t0, e0;
    int tcnt[4] = '{default: 0};
    localparam int DV[7] = '{4, 10, 16, 50, 64, 100, 200};
    four_channel_prescaled_timer u_dut (.clk_sys, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .timer_a_aux_input, .timer_b_aux_input, .io_line_four(io4), .io_line_three(1'b0), .timer_a_output,
        .timer_b_output, .timer_c_output, .timer_d_output, .timeout_pulse, .io_four_event, .io_three_event);
    aux_source u_aux_a (.clk_sys, .go(go_a), .n(n_tog), .line(timer_a_aux_input));
    aux_source u_aux_b (.clk_sys, .go(go_b), .n(n_tog), .line(timer_b_aux_input));
    // 200 MHz clock
    initial forever #2.5 clk_sys = ~clk_sys;
    // event tallies and hang limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 4; k++) if (timeout_pulse[k] === 1'b1) tcnt[k] <= tcnt[k] + 1;
        if (io_four_event === 1'b1) ev4 <= ev4 + 1;
        if (io_three_event === 1'b1) ev3 <= ev3 + 1;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ********************
    // tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] i);
        @(posedge clk_sys);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // cycles between two timeouts of timer k
    task automatic per(input int k, input int e);
        int n;
        n = 0;
        // a pulse seen on the return edge may still come from the old mode
        @(posedge clk_sys);
        while (timeout_pulse[k] !== 1'b1) @(posedge clk_sys);
        do begin
            @(posedge clk_sys);
            n++;
        end while (timeout_pulse[k] !== 1'b1);
        chk("period", n, e);
    endtask
    task automatic toggle(input bit b, input logic [3:0] n);
        @(posedge clk_sys);
        n_tog <= n;
        if (b) go_b <= 1'b1; else go_a <= 1'b1;
        @(posedge clk_sys);
        go_a <= 1'b0;
        go_b <= 1'b0;
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ********************
    // tests
    // ********************
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`IDX_TIMER_A_CTRL);
        chk("ctrl a", d, 32'h0);
        rd(6'h05);
        chk("unmapped", r, `RESP_SLVERR);
        wr(`IDX_TIMER_A_RELOAD, 8'h01);
        chk("bresp ok", r, `RESP_OKAY);
        wr(6'h05, 8'h00);
        chk("bresp unmapped", r, `RESP_SLVERR);
        wr(`IDX_TIMER_C_RELOAD, 8'h01);
        rd(`IDX_TIMER_C_RELOAD);
        chk("reload c", d, 32'h1);
        for (int c = 1; c < 8; c++) begin
            wr(`IDX_TIMER_CD_CTRL, {1'b0, c[2:0], 4'h0});
            per(2, DV[c-1]);
            wr(`IDX_TIMER_A_CTRL, {4'h0, c[3:0]});
            per(0, DV[c-1]);
        end
        wr(`IDX_TIMER_CD_CTRL, 8'hFF);
        rd(`IDX_TIMER_CD_CTRL);
        chk("cd ctrl", d, 32'h77);
        wr(`IDX_TIMER_D_RELOAD, 8'h00);
        wr(`IDX_TIMER_CD_CTRL, 8'h01);
        per(3, 1024);
        wr(`IDX_TIMER_CD_CTRL, 8'h00);
        chk("out d", timer_d_output, tcnt[3][0]);
        wr(`IDX_TIMER_A_CTRL, 8'h00);
        wr(`IDX_EDGE_POLARITY, 8'h18);
        wr(`IDX_TIMER_A_RELOAD, 8'h03);
        wr(`IDX_TIMER_A_CTRL, 8'h08);
        t0 = tcnt[0];
        e0 = ev4;
        o = timer_a_output;
        toggle(0, 4'h6);
        repeat (40) @(posedge clk_sys);
        chk("event timeouts", tcnt[0] - t0, 1);
        chk("aux a events", ev4 - e0, 3);
        chk("out a", timer_a_output, !o);
        rd(`IDX_TIMER_A_RELOAD);
        chk("count a", d, 32'h3);
        wr(`IDX_TIMER_A_CTRL, 8'h18);
        @(posedge clk_sys);
        chk("out a forced", timer_a_output, 1'b0);
        wr(`IDX_TIMER_B_RELOAD, 8'hC8);
        wr(`IDX_TIMER_B_CTRL, 8'h09);
        e0 = ev3;
        toggle(1, 4'h1);
        repeat (40) @(posedge clk_sys);
        chk("early event", ev3 - e0, 0);
        toggle(1, 4'h1);
        repeat (20) @(posedge clk_sys);
        chk("end event", ev3 - e0, 1);
        rd(`IDX_TIMER_B_RELOAD);
        chk("width", d inside {[188:191]}, 1);
        chk("out b", timer_b_output, 1'b0);
        wr(`IDX_TIMER_A_CTRL, 8'h00);
        e0 = ev4;
        @(posedge clk_sys);
        io4 <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("io four event", ev4 - e0, 1);
        wrap_up();
    end
endmodule
bind four_channel_prescaled_timer timer_checker u_chk (.clk_sys, .sys_rst, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .timer_a_output, .timer_c_output, .timeout_pulse);
